// ---- static_table_params.svh ----
/*
  Offsets, field positions, reset values and sizes of the static address
  and reserved multicast table access block, as text macros.
  Assumes it is included by bare name from the design file.
*/
`ifndef STATIC_TABLE_PARAMS_SVH
`define STATIC_TABLE_PARAMS_SVH

// ==========================================================================
// Register byte addresses
`define ADDR_WIDTH          16
`define OFS_TABLE_CTRL      16'h041c
`define OFS_ENTRY_FLAGS     16'h0420
`define OFS_ENTRY_PORTS     16'h0424
`define OFS_ENTRY_GROUP_HI  16'h0428
`define OFS_ENTRY_MAC_LO    16'h042c

// ==========================================================================
// Control register fields
`define CTL_INDEX_MSB       5
`define CTL_INDEX_LSB       0
`define CTL_ACTION_BIT      8
`define CTL_TABLE_SEL_BIT   9
`define CTL_GO_DONE_BIT     31
`define ACTION_WRITE        1'b0
`define ACTION_READ         1'b1
`define TABLE_STATIC        1'b0
`define TABLE_RESERVED      1'b1

// ==========================================================================
// Data register fields
`define FLG_VALID_BIT       31
`define FLG_SRC_DROP_BIT    30
`define FLG_DST_DROP_BIT    29
`define FLG_PRIO_MSB        28
`define FLG_PRIO_LSB        26
`define FLG_MST_MSB         2
`define FLG_MST_LSB         0
`define PRT_OVERRIDE_BIT    31
`define PRT_GROUP_MC_BIT    30
`define PRT_FWD_MSB         2
`define PRT_FWD_LSB         0
`define GRP_FID_MSB         22
`define GRP_FID_LSB         16
`define GRP_MAC_HI_MSB      15
`define GRP_MAC_HI_LSB      0

// ==========================================================================
// Table sizes and reset values
`define STATIC_ENTRIES      16
`define RSV_ADDRESSES       48
`define RSV_GROUPS          8
`define DATA_RESET          32'h0000_0000

`endif

// ---- static_table_pkg.sv ----
/*
  Types for the static address and reserved multicast table block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package static_table_pkg;

  // ========================================================================
  // Sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } op_state_t;

  // ========================================================================
  // One static entry, also the image of the four data registers
  typedef struct packed {
    logic        valid;
    logic        sourceDrop;
    logic        destDrop;
    logic [2:0]  priority_;
    logic [2:0]  mstGroup;
    logic        portOverride;
    logic        groupMatchOnMulticast;
    logic [2:0]  forwardPorts;
    logic [6:0]  filterGroupId;
    logic [47:0] mac;
  } static_entry_t;

  // ========================================================================
  // Whole state of the access block
  typedef struct packed {
    op_state_t          fsm;
    logic [5:0]         ctlIndex;
    logic               ctlAction;
    logic               ctlTableSel;
    logic               opGoDone;
    static_entry_t      stage;
    static_entry_t [15:0] table_;
    logic [7:0][2:0]    rsvGroupPorts;
    logic [31:0]        rdata;
    logic               lkHit;
    logic               lkDrop;
    logic [2:0]         lkPorts;
    logic               lkOverride;
    logic [2:0]         lkPriority;
    logic [2:0]         rsvPorts;
  } table_state_t;

endpackage

// ---- static_table_access.sv ----
/*
  Indirect host access to the 16-entry static address table and the
  48-address reserved multicast table, plus the match logic that the
  forwarding path consults.
  Assumes a synchronous register port and a lookup requester on clk.
*/
// What this block does
// - Flags register bit 31 marks entry valid; resets to zero.
// - Source-drop set on matching entry drops packet during source learning.
// - Destination-drop set on matching entry drops packet during lookup.
// - Flags bits 2:0 hold spanning tree group used for matching.
// - Ports register bit 31 lets entry override port blocking state.
// - Ports register bit 30 adds filter group to multicast matching.
// - Ports bits 2,1,0 enable forwarding to ports 3,2,1.
// - Third register bits 22:16 hold seven-bit filter group id.
// - Reserved multicast table holds port masks for 48 addresses.
// - Reserved table indexed by six low address bits.
// - 48 addresses form 8 groups; a write changes the whole group.
// - Reserved table uses same control, data only in ports register.
// - Table select 1 directs operation to reserved table.
// - Action 0 writes data registers into indexed entry.
// - Action 1 loads indexed entry into data registers.
// - Writing go bit starts operation; hardware clears it when done.
// - Table select 0 directs operation to static table.
// - Static table has 16 entries, 4-bit index, never aged.
`timescale 1ns/1ps
`include "static_table_params.svh"

module static_table_access (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  input  wire logic        lookupReq,
  input  wire logic [47:0] lookupMac,
  input  wire logic        lookupIsSource,
  input  wire logic        lookupMulticast,
  input  wire logic [6:0]  lookupFid,
  input  wire logic [2:0]  lookupMst,
  output logic             lookupHit,
  output logic             lookupDrop,
  output logic      [2:0]  lookupPorts,
  output logic             lookupOverride,
  output logic      [2:0]  lookupPriority,
  input  wire logic [5:0]  rsvLookupIndex,
  output logic      [2:0]  rsvLookupPorts,
  output logic             opBusy
);

  // ========================================================================
  // State
  static_table_pkg::table_state_t cur;
  static_table_pkg::table_state_t next_cur;
  logic [15:0]                    matchVec;

  // ========================================================================
  // Fixed grouping of the 48 reserved addresses
  function automatic logic [2:0] rsvGroupOf(input logic [5:0] idx);
    logic [2:0] g;
    g = 3'h7;
    case (idx)
      6'h00: g = 3'h0;
      6'h01: g = 3'h1;
      6'h03: g = 3'h2;
      6'h10: g = 3'h3;
      6'h20: g = 3'h4;
      6'h21: g = 3'h5;
      6'h02, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a,
      6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f: g = 3'h6;
      default: g = 3'h7;
    endcase
    return g;
  endfunction

  // Only the first 48 index values name a reserved address
  function automatic logic rsvInRange(input logic [5:0] idx);
    return idx < 6'(`RSV_ADDRESSES);
  endfunction

  // ========================================================================
  // Register views of the staged entry
  function automatic logic [31:0] viewFlags(
    input static_table_pkg::static_entry_t e);
    logic [31:0] v;
    v = `DATA_RESET;
    v[`FLG_VALID_BIT]                 = e.valid;
    v[`FLG_SRC_DROP_BIT]              = e.sourceDrop;
    v[`FLG_DST_DROP_BIT]              = e.destDrop;
    v[`FLG_PRIO_MSB:`FLG_PRIO_LSB]    = e.priority_;
    v[`FLG_MST_MSB:`FLG_MST_LSB]      = e.mstGroup;
    return v;
  endfunction

  function automatic logic [31:0] viewPorts(
    input static_table_pkg::static_entry_t e);
    logic [31:0] v;
    v = `DATA_RESET;
    v[`PRT_OVERRIDE_BIT]          = e.portOverride;
    v[`PRT_GROUP_MC_BIT]          = e.groupMatchOnMulticast;
    v[`PRT_FWD_MSB:`PRT_FWD_LSB]  = e.forwardPorts;
    return v;
  endfunction

  function automatic logic [31:0] viewGroupHi(
    input static_table_pkg::static_entry_t e);
    logic [31:0] v;
    v = `DATA_RESET;
    v[`GRP_FID_MSB:`GRP_FID_LSB]       = e.filterGroupId;
    v[`GRP_MAC_HI_MSB:`GRP_MAC_HI_LSB] = e.mac[47:32];
    return v;
  endfunction

  // ========================================================================
  // Per-entry match, one comparator set per static entry
  genvar gi;
  generate
    for (gi = 0; gi < `STATIC_ENTRIES; gi++) begin : g_match
      static_table_pkg::static_entry_t ent;
      logic                            fidOk;
      assign ent = cur.table_[gi];
      // Filter group counts for unicast, and for multicast only on request
      assign fidOk = (lookupMulticast && !ent.groupMatchOnMulticast) ||
                     (ent.filterGroupId == lookupFid);
      assign matchVec[gi] = ent.valid && (ent.mac == lookupMac) &&
                            (ent.mstGroup == lookupMst) && fidOk;
    end
  endgenerate

  // ========================================================================
  // Next-state logic
  always_comb begin
    logic       hit;
    logic [3:0] hitIdx;
    logic [3:0] sIdx;
    logic [2:0] grp;
    static_table_pkg::static_entry_t hitEnt;
    hit      = 1'b0;
    hitIdx   = 4'h0;
    sIdx     = 4'h0;
    grp      = 3'h0;
    hitEnt   = '0;
    next_cur = cur;

    // Lowest matching index wins; entries never age out
    for (int i = `STATIC_ENTRIES - 1; i >= 0; i--) begin
      if (matchVec[i]) begin
        hit    = 1'b1;
        hitIdx = 4'(i);
      end
    end
    hitEnt = cur.table_[hitIdx];

    // Lookup answer, one cycle after the request
    next_cur.lkHit      = lookupReq && hit;
    next_cur.lkDrop     = lookupReq && hit &&
                          (lookupIsSource ? hitEnt.sourceDrop
                                          : hitEnt.destDrop);
    next_cur.lkPorts    = (lookupReq && hit) ? hitEnt.forwardPorts : 3'h0;
    next_cur.lkOverride = lookupReq && hit && hitEnt.portOverride;
    next_cur.lkPriority = (lookupReq && hit) ? hitEnt.priority_ : 3'h0;

    // Reserved multicast lookup by the six low address bits
    next_cur.rsvPorts = rsvInRange(rsvLookupIndex) ?
      cur.rsvGroupPorts[rsvGroupOf(rsvLookupIndex)] : 3'h0;

    // Read data: valid in the cycle after the strobe only
    next_cur.rdata = `DATA_RESET;
    if (regRead) begin
      case (regAddr)
        `OFS_TABLE_CTRL: begin
          next_cur.rdata[`CTL_INDEX_MSB:`CTL_INDEX_LSB] = cur.ctlIndex;
          next_cur.rdata[`CTL_ACTION_BIT]    = cur.ctlAction;
          next_cur.rdata[`CTL_TABLE_SEL_BIT] = cur.ctlTableSel;
          next_cur.rdata[`CTL_GO_DONE_BIT]   = cur.opGoDone;
        end
        `OFS_ENTRY_FLAGS:    next_cur.rdata = viewFlags(cur.stage);
        `OFS_ENTRY_PORTS:    next_cur.rdata = viewPorts(cur.stage);
        `OFS_ENTRY_GROUP_HI: next_cur.rdata = viewGroupHi(cur.stage);
        `OFS_ENTRY_MAC_LO:   next_cur.rdata = cur.stage.mac[31:0];
        default:             next_cur.rdata = `DATA_RESET;
      endcase
    end

    // Host writes to data registers; reserved bits stay zero
    if (regWrite) begin
      case (regAddr)
        `OFS_ENTRY_FLAGS: begin
          next_cur.stage.valid      = regWdata[`FLG_VALID_BIT];
          next_cur.stage.sourceDrop = regWdata[`FLG_SRC_DROP_BIT];
          next_cur.stage.destDrop   = regWdata[`FLG_DST_DROP_BIT];
          next_cur.stage.priority_  =
            regWdata[`FLG_PRIO_MSB:`FLG_PRIO_LSB];
          next_cur.stage.mstGroup   =
            regWdata[`FLG_MST_MSB:`FLG_MST_LSB];
        end
        `OFS_ENTRY_PORTS: begin
          // Same register carries the reserved multicast mask
          next_cur.stage.portOverride          =
            regWdata[`PRT_OVERRIDE_BIT];
          next_cur.stage.groupMatchOnMulticast =
            regWdata[`PRT_GROUP_MC_BIT];
          next_cur.stage.forwardPorts          =
            regWdata[`PRT_FWD_MSB:`PRT_FWD_LSB];
        end
        `OFS_ENTRY_GROUP_HI: begin
          next_cur.stage.filterGroupId =
            regWdata[`GRP_FID_MSB:`GRP_FID_LSB];
          next_cur.stage.mac[47:32]    =
            regWdata[`GRP_MAC_HI_MSB:`GRP_MAC_HI_LSB];
        end
        `OFS_ENTRY_MAC_LO: begin
          next_cur.stage.mac[31:0] = regWdata;
        end
        default: begin
        end
      endcase
    end

    // Operation sequencer
    sIdx = cur.ctlIndex[3:0];
    grp  = rsvGroupOf(cur.ctlIndex);
    case (cur.fsm)
      static_table_pkg::ST_IDLE: begin
      end
      static_table_pkg::ST_EXEC: begin
        if (cur.ctlTableSel == `TABLE_STATIC) begin
          if (cur.ctlAction == `ACTION_WRITE) begin
            next_cur.table_[sIdx] = cur.stage;
          end else begin
            next_cur.stage = cur.table_[sIdx];
          end
        end else if (rsvInRange(cur.ctlIndex)) begin
          if (cur.ctlAction == `ACTION_WRITE) begin
            // Whole group changes together
            next_cur.rsvGroupPorts[grp] = cur.stage.forwardPorts;
          end else begin
            // Only the mask field is loaded; other bits keep their value
            next_cur.stage.forwardPorts = cur.rsvGroupPorts[grp];
          end
        end
        next_cur.opGoDone = 1'b0;
        next_cur.fsm      = static_table_pkg::ST_IDLE;
      end
      default: begin
        next_cur.fsm      = static_table_pkg::ST_IDLE;
        next_cur.opGoDone = 1'b0;
      end
    endcase

    // Control write last, so a new start beats the completion clear
    if (regWrite && regAddr == `OFS_TABLE_CTRL) begin
      next_cur.ctlIndex    =
        regWdata[`CTL_INDEX_MSB:`CTL_INDEX_LSB];
      next_cur.ctlAction   = regWdata[`CTL_ACTION_BIT];
      next_cur.ctlTableSel = regWdata[`CTL_TABLE_SEL_BIT];
      if (regWdata[`CTL_GO_DONE_BIT]) begin
        next_cur.opGoDone = 1'b1;
        next_cur.fsm      = static_table_pkg::ST_EXEC;
      end
    end
  end

  // ========================================================================
  // State register; all fields clear at reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ========================================================================
  // Outputs, all straight from flip-flops
  assign regRdata       = cur.rdata;
  assign lookupHit      = cur.lkHit;
  assign lookupDrop     = cur.lkDrop;
  assign lookupPorts    = cur.lkPorts;
  assign lookupOverride = cur.lkOverride;
  assign lookupPriority = cur.lkPriority;
  assign rsvLookupPorts = cur.rsvPorts;
  assign opBusy         = cur.opGoDone;

endmodule

// ---- static_table_properties.sv ----
/*
  Timing checker for the table access block, bound to its top module.
  Assumes one clock, clk, and an asynchronous active high rst.
*/
`timescale 1ns/1ps
module static_table_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic        lookupReq,
  input wire logic        lookupHit,
  input wire logic        lookupDrop,
  input wire logic [2:0]  lookupPorts,
  input wire logic [5:0]  rsvLookupIndex,
  input wire logic [2:0]  rsvLookupPorts,
  input wire logic        opBusy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Helpers
  logic goWr;
  // A control write that launches an operation
  assign goWr = regWrite && regAddr == 16'h041c && regWdata[31];

  // ==========================================================================
  // Operation handshake
  go_sets_busy_a: assert property (goWr |=> opBusy)
    else $error("launch did not set busy");
  busy_self_clear_a: assert property (opBusy && !goWr |=> !opBusy)
    else $error("busy held past one cycle");
  busy_has_cause_a: assert property ($rose(opBusy) |-> $past(goWr))
    else $error("busy rose without launch");

  // ==========================================================================
  // Register read port
  read_idle_zero_a: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data outside read slot");
  flags_rsvd_a: assert property ($past(regRead) && $past(regAddr) == 16'h0420
    |-> regRdata[25:3] == 23'h0) else $error("flags reserved bits");
  ports_rsvd_a: assert property ($past(regRead) && $past(regAddr) == 16'h0424
    |-> regRdata[29:3] == 27'h0) else $error("ports reserved bits");
  group_rsvd_a: assert property ($past(regRead) && $past(regAddr) == 16'h0428
    |-> regRdata[31:23] == 9'h0) else $error("group reserved bits");
  unmapped_read_a: assert property ($past(regRead) && ($past(regAddr) >
    16'h042c || $past(regAddr) < 16'h041c) |-> regRdata == 32'h0)
    else $error("unmapped read not zero");

  // ==========================================================================
  // Lookup outputs
  miss_quiet_a: assert property (!lookupHit |-> lookupPorts == 3'h0 &&
    !lookupDrop) else $error("miss carries ports or drop");
  rsv_range_a: assert property (rsvLookupIndex >= 6'h30 |=>
    rsvLookupPorts == 3'h0) else $error("index past 47 has ports");

  // Main scenarios
  cover property (goWr ##1 opBusy ##1 !opBusy);
  cover property (lookupReq ##1 lookupHit);
  cover property (rsvLookupPorts != 3'h0);
endmodule

bind static_table_access static_table_properties static_table_properties_inst (
  .clk, .rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .lookupReq,
  .lookupHit, .lookupDrop, .lookupPorts, .rsvLookupIndex, .rsvLookupPorts,
  .opBusy);

// ---- host_bus_model.sv ----
/*
  Host processor model driving the register port one strobe at a time.
  Assumes the block answers reads one cycle later and never stalls.
*/
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic  clk,
  output logic [15:0] regAddr,
  output logic [31:0] regWdata,
  output logic        regWrite,
  output logic        regRead
);
  // ==========================================================================
  // Idle bus at time zero
  initial begin
    regAddr  = 16'h0;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead  = 1'b0;
  end

  // One-cycle write strobe; data inverted as the strobe drops
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regWdata <= ~d; // Stale data must not be reused
  endtask

  // One-cycle read strobe; the bench collects the answer
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
  endtask
endmodule

// ---- static_table_access_tb.sv ----
/*
  Self-checking bench for the table access block.
  Assumes the host model in its own file and the bound checker.
*/
`timescale 1ns/1ps
module static_table_access_tb;
  logic        clk, rst, regWrite, regRead, lookupReq, lookupIsSource;
  logic        lookupMulticast, lookupHit, lookupDrop, lookupOverride, opBusy;
  logic [15:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic [47:0] lookupMac, mac;
  logic [6:0]  lookupFid;
  logic [2:0]  lookupMst, lookupPorts, lookupPriority, rsvLookupPorts;
  logic [5:0]  rsvLookupIndex;
  logic [31:0] a[4], ea[4], b;
  logic [31:0] msk[4] = '{32'hfc000007, 32'hc0000007, 32'h007fffff, '1};
  logic [31:0] rdQ[$];
  logic [8:0]  lkQ[$];
  logic        rdSeen = 1'b0, lkSeen = 1'b0, busyExp = 1'b0;
  int          errors = 0, checks = 0;

  // ==========================================================================
  // Clock, design and host
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  static_table_access static_table_access_inst (.clk, .rst, .regAddr,
    .regWdata, .regWrite, .regRead, .regRdata, .lookupReq, .lookupMac,
    .lookupIsSource, .lookupMulticast, .lookupFid, .lookupMst, .lookupHit,
    .lookupDrop, .lookupPorts, .lookupOverride, .lookupPriority,
    .rsvLookupIndex, .rsvLookupPorts, .opBusy);
  host_bus_model host_bus_model_inst (.clk, .regAddr, .regWdata, .regWrite,
    .regRead);

  // ==========================================================================
  // Checking helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic rdx(input logic [15:0] ad, input logic [31:0] e);
    rdQ.push_back(e);
    host_bus_model_inst.rd(ad);
  endtask
  task automatic lk(input logic [47:0] m, input logic s, input logic mc,
                    input logic [6:0] f, input logic [2:0] t,
                    input logic [8:0] e);
    @(posedge clk);
    lookupMac <= m; lookupIsSource <= s; lookupMulticast <= mc;
    lookupFid <= f; lookupMst <= t; lookupReq <= 1'b1;
    lkQ.push_back(e);
    @(posedge clk);
    lookupReq <= 1'b0;
  endtask
  // Expected lookup answer: hit, drop, ports, override, priority
  function automatic logic [8:0] ex(input logic h, input logic s);
    return h ? {1'b1, s ? ea[0][30] : ea[0][29], ea[1][2:0], ea[1][31],
                ea[0][28:26]} : 9'h0;
  endfunction

  // Result watcher: oldest note against each answer
  always @(posedge clk) begin
    if (rdSeen) chk(regRdata, rdQ.pop_front());
    if (lkSeen) chk(32'({lookupHit, lookupDrop, lookupPorts, lookupOverride,
      lookupPriority}), 32'(lkQ.pop_front()));
    chk(32'(opBusy), 32'(busyExp));
    rdSeen <= regRead;
    lkSeen <= lookupReq;
    // Busy expected for exactly the cycle after a launching control write
    busyExp <= regWrite && regAddr == 16'h041c && regWdata[31];
  end

  // Hang guard, far beyond the hundred or so cycles needed
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    conclude();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'h82cb56d7));
    rst = 1'b1; lookupReq = 1'b0; lookupMac = '0; lookupIsSource = 1'b0;
    lookupMulticast = 1'b0; lookupFid = '0; lookupMst = '0;
    rsvLookupIndex = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped address past the block included
    for (int i = 0; i < 6; i++) rdx(16'h041c + 16'(4 * i), 32'h0);
    // Static write of a random entry to the last index, valid bit set
    for (int i = 0; i < 4; i++) begin
      a[i] = $urandom | (i == 0 ? 32'h80000000 : 32'h0);
      ea[i] = a[i] & msk[i];
      host_bus_model_inst.wr(16'h0420 + 16'(4 * i), a[i]);
    end
    host_bus_model_inst.wr(16'h041c, 32'h8000000f);
    // Scribble over the staging registers and read them back
    for (int i = 0; i < 4; i++) begin
      b = $urandom;
      host_bus_model_inst.wr(16'h0420 + 16'(4 * i), b);
      rdx(16'h0420 + 16'(4 * i), b & msk[i]);
    end
    // Read operation restores the stored entry
    host_bus_model_inst.wr(16'h041c, 32'h8000010f);
    for (int i = 0; i < 4; i++) rdx(16'h0420 + 16'(4 * i), ea[i]);
    rdx(16'h041c, 32'h0000010f);
    // Lookups: both drop kinds, misses, multicast filter group
    mac = {ea[2][15:0], ea[3]};
    lk(mac, 1'b1, 1'b0, ea[2][22:16], ea[0][2:0], ex(1'b1, 1'b1));
    lk(mac, 1'b0, 1'b0, ea[2][22:16], ea[0][2:0], ex(1'b1, 1'b0));
    lk(mac ^ 48'h1, 1'b0, 1'b0, ea[2][22:16], ea[0][2:0], 9'h0);
    lk(mac, 1'b0, 1'b0, ea[2][22:16], ea[0][2:0] + 3'h1, 9'h0);
    lk(mac, 1'b0, 1'b0, ea[2][22:16] + 7'h1, ea[0][2:0], 9'h0);
    lk(mac, 1'b0, 1'b1, ea[2][22:16] + 7'h1, ea[0][2:0],
       ex(!ea[1][30], 1'b0));
    lk(48'h0, 1'b0, 1'b0, 7'h0, 3'h0, 9'h0);
    // Reserved table: mask loaded first, then launched
    host_bus_model_inst.wr(16'h0424, 32'hc0000005);
    host_bus_model_inst.wr(16'h041c, 32'h80000204);
    host_bus_model_inst.wr(16'h0424, 32'h80000002);
    host_bus_model_inst.wr(16'h041c, 32'h8000030f);
    rdx(16'h0424, 32'h80000005);
    host_bus_model_inst.wr(16'h041c, 32'h80000301);
    rdx(16'h0424, 32'h80000000);
    rdx(16'h041c, 32'h00000301);
    // Forwarding side: group member, outsider, out of range
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      rsvLookupIndex <= i == 0 ? 6'h0c : i == 1 ? 6'h04 : i == 2 ? 6'h01
                      : 6'h30;
      repeat (2) @(posedge clk);
      chk(32'(rsvLookupPorts), i < 2 ? 32'h5 : 32'h0);
    end
    repeat (3) @(posedge clk);
    conclude();
  end
endmodule
